// [core/mcg_pkg.sv]
// constants shared by the modem controller glue block
package mcg_pkg;
  // controller data space addresses
  localparam logic [19:0] MCG_ADDR_LINE_PORT = 20'h0_D000;
  localparam logic [19:0] MCG_ADDR_DIV_READ  = 20'h0_EC00;
  localparam logic [19:0] MCG_ADDR_UART_CLK  = 20'hD_4000;
  // line interface port bit positions
  localparam int MCG_LINE_DSP_RST = 0;
  localparam int MCG_LINE_OUT1    = 1;
  localparam int MCG_LINE_OUT2    = 2;
  localparam int MCG_LINE_OUT0    = 4;
  // reset values
  localparam logic [7:0] MCG_UART_CLK_RST  = 8'h06;
  localparam logic [7:0] MCG_LINE_PORT_RST = 8'h00;
  localparam logic [7:0] MCG_READ_ZERO     = 8'h00;
  // divider field: bits 6..1 hold half of the even ratio
  localparam int         MCG_DIV_LSB  = 1;
  localparam int         MCG_DIV_MSB  = 6;
  localparam logic [5:0] MCG_HALF_MIN = 6'h01;
  localparam logic [5:0] MCG_HALF_MAX = 6'h20;
  // external program fetch timing, in clock cycles
  localparam logic [3:0] MCG_FETCH_CYCLES = 4'h3;
  // operating modes taken from the straps
  typedef enum logic [1:0] {
    MCG_MODE_INTERNAL,
    MCG_MODE_EXTERNAL,
    MCG_MODE_TEST
  } mcg_mode_t;
endpackage : mcg_pkg

// [core/mcg_uart_clk_div.sv]
// even divider that makes the emulated uart clock from the crystal
`timescale 1ns/10ps
`default_nettype none
module mcg_uart_clk_div
  import mcg_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  input  wire logic [5:0] half_in,
  output var  logic       uart_clk_out,
  output var  logic       uart_tick_out
);
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic [5:0] half;
  logic       clk_ff;
  logic       nxt_clk;
  logic       tick_ff;
  logic       nxt_tick;

  ////////////////////////////////////////////////////////////////////////////
  // zero ratio would stall the uart, so it acts as the smallest ratio
  always_comb begin
    half = half_in;
    if (half_in < MCG_HALF_MIN) begin
      half = MCG_HALF_MIN;
    end else if (half_in > MCG_HALF_MAX) begin
      half = MCG_HALF_MAX;
    end
    nxt_cnt  = cnt_ff + 6'h01;
    nxt_clk  = clk_ff;
    nxt_tick = 1'b0;
    // toggle every half ratio keeps the duty cycle at 50 percent
    if (cnt_ff >= half) begin
      nxt_cnt  = MCG_HALF_MIN;
      nxt_clk  = ~clk_ff;
      nxt_tick = ~clk_ff;
    end
  end

  // registers only
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      cnt_ff  <= MCG_HALF_MIN;
      clk_ff  <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      clk_ff  <= nxt_clk;
      tick_ff <= nxt_tick;
    end
  end

  assign uart_clk_out  = clk_ff;
  assign uart_tick_out = tick_ff;
endmodule : mcg_uart_clk_div
`default_nettype wire

// [core/mcg_glue.sv]
// modem controller glue: straps, bank switch, line port, uart clock
`timescale 1ns/10ps
`default_nettype none
module mcg_glue
  import mcg_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        config_select_low_in,
  input  wire logic        config_select_high_in,
  input  wire logic        pnp_enable_n_in,
  input  wire logic        pnp_key_in,
  input  wire logic        bank_port_bit_in,
  input  wire logic [19:0] dbus_addr_in,
  input  wire logic [7:0]  dbus_wdata_in,
  input  wire logic        dbus_wr_in,
  input  wire logic        dbus_rd_in,
  input  wire logic [7:0]  uart_div_low_in,
  input  wire logic        fetch_req_in,
  output var  logic [7:0]  dbus_rdata_out,
  output var  logic [1:0]  mode_out,
  output var  logic        uart_enable_out,
  output var  logic        parallel_if_enable_out,
  output var  logic        serial_if_enable_out,
  output var  logic        pnp_mode_out,
  output var  logic        bank_select_out,
  output var  logic        dsp_reset_n_out,
  output var  logic        line_control_out0,
  output var  logic        line_control_out1,
  output var  logic        line_control_out2,
  output var  logic        uart_clk_out,
  output var  logic        uart_tick_out,
  output var  logic        addr_latch_pulse_out,
  output var  logic        prog_fetch_n_out
);
  typedef enum logic [1:0] {MCG_F_IDLE, MCG_F_LATCH, MCG_F_FETCH} mcg_fst_t;

  // pin synchronisers: three stages, change accepted when 2 and 3 agree
  logic [2:0] sync_ff [3];
  logic [2:0] nxt_sync [3];
  logic [2:0] pin_raw;
  logic [2:0] strap_ff;
  logic [2:0] nxt_strap;
  // control and status state
  mcg_mode_t  mode_ff, nxt_mode;
  logic       uart_en_ff, nxt_uart_en;
  logic       par_en_ff, nxt_par_en;
  logic       ser_en_ff, nxt_ser_en;
  logic       pnp_ff, nxt_pnp;
  logic       bank_ff, nxt_bank;
  logic [7:0] line_ff, nxt_line;
  logic [7:0] uclk_ff, nxt_uclk;
  logic [7:0] rdata_ff, nxt_rdata;
  // fetch sequencer
  mcg_fst_t   fst_ff, nxt_fst;
  logic [3:0] fcnt_ff, nxt_fcnt;
  logic       ale_ff, nxt_ale;
  logic       prog_fetch_n_n_ff, nxt_prog_fetch_n_n;

  assign pin_raw = {pnp_enable_n_in, config_select_high_in,
                    config_select_low_in};

  ////////////////////////////////////////////////////////////////////////////
  // one synchroniser per strap pin; stage 1 feeds stage 2 only
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_comb begin
        nxt_sync[g] = {sync_ff[g][1:0], pin_raw[g]};
        nxt_strap[g] = strap_ff[g];
        if (sync_ff[g][1] == sync_ff[g][2]) begin
          nxt_strap[g] = sync_ff[g][2];
        end
      end
      // constant reset; the strap is followed after release
      always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
          sync_ff[g]  <= 3'h0;
          strap_ff[g] <= 1'b0;
        end else begin
          sync_ff[g]  <= nxt_sync[g];
          strap_ff[g] <= nxt_strap[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // mode decode, pnp gate, bank switch, data space registers
  always_comb begin
    nxt_mode = MCG_MODE_INTERNAL;
    if (strap_ff[1]) begin
      nxt_mode = MCG_MODE_TEST;
    end else if (strap_ff[0]) begin
      nxt_mode = MCG_MODE_EXTERNAL;
    end
    nxt_uart_en = (nxt_mode == MCG_MODE_INTERNAL);
    nxt_par_en  = (nxt_mode == MCG_MODE_INTERNAL);
    nxt_ser_en  = (nxt_mode == MCG_MODE_EXTERNAL);
    // the pin wins over a key pulse; a high pin drops pnp
    nxt_pnp = pnp_ff;
    if (strap_ff[2]) begin
      nxt_pnp = 1'b0;
    end else if (pnp_key_in) begin
      nxt_pnp = 1'b1;
    end
    // cleared port bit means upper bank; jump timing is firmware's job
    nxt_bank = ~bank_port_bit_in;
    nxt_line = line_ff;
    nxt_uclk = uclk_ff;
    if (dbus_wr_in && dbus_addr_in == MCG_ADDR_LINE_PORT) begin
      nxt_line = dbus_wdata_in;
    end
    if (dbus_wr_in && dbus_addr_in == MCG_ADDR_UART_CLK) begin
      nxt_uclk = {1'b0, dbus_wdata_in[MCG_DIV_MSB:MCG_DIV_LSB], 1'b0};
    end
    // write-only registers and unmapped addresses read as zero
    nxt_rdata = MCG_READ_ZERO;
    if (dbus_rd_in && dbus_addr_in == MCG_ADDR_DIV_READ) begin
      nxt_rdata = uart_div_low_in;
    end
  end

  // registers only
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      mode_ff    <= MCG_MODE_INTERNAL;
      // reset mode is internal, so its interfaces start enabled with it
      uart_en_ff <= 1'b1;
      par_en_ff  <= 1'b1;
      ser_en_ff  <= 1'b0;
      pnp_ff     <= 1'b0;
      bank_ff    <= 1'b0;
      line_ff    <= MCG_LINE_PORT_RST;
      uclk_ff    <= MCG_UART_CLK_RST;
      rdata_ff   <= MCG_READ_ZERO;
    end else begin
      mode_ff    <= nxt_mode;
      uart_en_ff <= nxt_uart_en;
      par_en_ff  <= nxt_par_en;
      ser_en_ff  <= nxt_ser_en;
      pnp_ff     <= nxt_pnp;
      bank_ff    <= nxt_bank;
      line_ff    <= nxt_line;
      uclk_ff    <= nxt_uclk;
      rdata_ff   <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external program fetch: one latch cycle, then strobe low
  always_comb begin
    nxt_fst    = fst_ff;
    nxt_fcnt   = fcnt_ff;
    nxt_ale    = 1'b0;
    nxt_prog_fetch_n_n = 1'b1;
    unique case (fst_ff)
      MCG_F_IDLE: begin
        if (fetch_req_in) begin
          nxt_fst = MCG_F_LATCH;
          nxt_ale = 1'b1;
        end
      end
      MCG_F_LATCH: begin
        nxt_fst    = MCG_F_FETCH;
        nxt_fcnt   = MCG_FETCH_CYCLES;
        nxt_prog_fetch_n_n = 1'b0;
      end
      MCG_F_FETCH: begin
        nxt_fcnt   = fcnt_ff - 4'h1;
        nxt_prog_fetch_n_n = 1'b0;
        if (fcnt_ff == 4'h1) begin
          nxt_fst    = MCG_F_IDLE;
          nxt_prog_fetch_n_n = 1'b1;
        end
      end
    endcase
  end

  // registers only
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      fst_ff    <= MCG_F_IDLE;
      fcnt_ff   <= 4'h0;
      ale_ff    <= 1'b0;
      prog_fetch_n_n_ff <= 1'b1;
    end else begin
      fst_ff    <= nxt_fst;
      fcnt_ff   <= nxt_fcnt;
      ale_ff    <= nxt_ale;
      prog_fetch_n_n_ff <= nxt_prog_fetch_n_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // uart clock; exact 1.8432 mhz needs a crystal at an even multiple
  mcg_uart_clk_div u_div (
    .ref_clk_in    (ref_clk_in),
    .nrst_in       (nrst_in),
    .half_in       (uclk_ff[MCG_DIV_MSB:MCG_DIV_LSB]),
    .uart_clk_out  (uart_clk_out),
    .uart_tick_out (uart_tick_out)
  );

  // output assignments, all from flip-flops
  assign dbus_rdata_out         = rdata_ff;
  assign mode_out               = mode_ff;
  assign uart_enable_out        = uart_en_ff;
  assign parallel_if_enable_out = par_en_ff;
  assign serial_if_enable_out   = ser_en_ff;
  assign pnp_mode_out           = pnp_ff;
  assign bank_select_out        = bank_ff;
  assign dsp_reset_n_out        = line_ff[MCG_LINE_DSP_RST];
  assign line_control_out1      = line_ff[MCG_LINE_OUT1];
  assign line_control_out2      = line_ff[MCG_LINE_OUT2];
  assign line_control_out0      = line_ff[MCG_LINE_OUT0];
  assign addr_latch_pulse_out   = ale_ff;
  assign prog_fetch_n_out       = prog_fetch_n_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  test_mode_a: assert property (
    strap_ff[1] |=> mode_ff == MCG_MODE_TEST)
    else $error("test strap did not give test mode");
  internal_uart_a: assert property (
    mode_ff == MCG_MODE_INTERNAL |-> uart_en_ff && par_en_ff && !ser_en_ff)
    else $error("internal mode enables wrong interfaces");
  external_serial_a: assert property (
    mode_ff == MCG_MODE_EXTERNAL |-> !uart_en_ff && ser_en_ff)
    else $error("external mode enables wrong interfaces");
  pnp_gate_a: assert property (strap_ff[2] |=> !pnp_ff)
    else $error("pnp active with enable pin high");
  bank_follow_a: assert property (
    bank_select_out == !$past(bank_port_bit_in))
    else $error("bank select does not follow port bit");
  div_write_a: assert property (
    dbus_wr_in && dbus_addr_in == MCG_ADDR_UART_CLK |=>
      uclk_ff[0] == 1'b0 && uclk_ff[7] == 1'b0 &&
      uclk_ff[6:1] == $past(dbus_wdata_in[6:1]))
    else $error("divider write stored wrong value");
  readback_a: assert property (
    dbus_rd_in && dbus_addr_in == MCG_ADDR_DIV_READ |=>
      dbus_rdata_out == $past(uart_div_low_in))
    else $error("divisor read-back wrong");
  line_port_a: assert property (
    dbus_wr_in && dbus_addr_in == MCG_ADDR_LINE_PORT |=>
      line_control_out1 == $past(dbus_wdata_in[1]) &&
      line_control_out2 == $past(dbus_wdata_in[2]) &&
      line_control_out0 == $past(dbus_wdata_in[4]))
    else $error("line outputs do not follow port write");
  fetch_seq_a: assert property (
    fst_ff == MCG_F_IDLE && fetch_req_in |=>
      addr_latch_pulse_out && prog_fetch_n_out ##1
      !addr_latch_pulse_out && !prog_fetch_n_out [*3] ##1 prog_fetch_n_out)
    else $error("fetch sequence wrong");
  uart_tick_a: assert property (
    uart_tick_out |-> uart_clk_out && !$past(uart_clk_out))
    else $error("uart tick without rising clock");

  ext_mode_c: cover property (mode_ff == MCG_MODE_EXTERNAL);
  pnp_enter_c: cover property (!pnp_ff ##1 pnp_ff);
  bank_swap_c: cover property (!bank_ff ##1 bank_ff ##[1:20] !bank_ff);
  fetch_c: cover property (addr_latch_pulse_out ##1 !prog_fetch_n_out);
endmodule : mcg_glue
`default_nettype wire

// [tb/mcg_fw_model.sv]
// firmware model: bank port bit then a jump fetch
`timescale 1ns/10ps
`default_nettype none
module mcg_fw_model (
  input  wire logic ref_clk_in,
  input  wire logic jump_in,
  input  wire logic upper_in,
  output var  logic bank_port_bit_out,
  output var  logic fetch_req_out
);
  logic jumping;
  initial begin
    bank_port_bit_out = 1'b1;
    fetch_req_out     = 1'b0;
    jumping           = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // port bit first, jump fetch one cycle later; no gap is allowed between
  always @(negedge ref_clk_in) begin
    fetch_req_out <= jumping;
    jumping       <= 1'b0;
    if (jump_in) begin
      bank_port_bit_out <= ~upper_in;
      jumping           <= 1'b1;
    end
  end
endmodule : mcg_fw_model
`default_nettype wire

// [tb/test_modem_controller_glue.sv]
// self-checking bench for the modem controller glue
`timescale 1ns/10ps
`default_nettype none
module test_modem_controller_glue
  import mcg_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, sel_lo = 1'b0, sel_hi = 1'b0;
  logic pnp_n = 1'b0, key = 1'b0, wr = 1'b0, rd = 1'b0;
  logic jump = 1'b0, upper = 1'b0, port_bit, freq;
  logic [19:0] addr = 20'h0_0000;
  logic [7:0]  wdata = 8'h00, div_low = 8'h00, rdata;
  logic [1:0]  mode;
  logic        uart_en, par_en, ser_en, pnp, bank, dsp_n, lc0, lc1, lc2;
  logic        uclk, tick, ale, prog_fetch_n_n;
  int          miscompares = 0, check_count = 0, i, n;
  //////////////////////////////////////////////////////////////////////////
  // 40 MHz crystal
  always #12.5 clk = ~clk;
  mcg_fw_model u_fw (.ref_clk_in(clk), .jump_in(jump), .upper_in(upper),
    .bank_port_bit_out(port_bit), .fetch_req_out(freq));
  mcg_glue u_dut (.ref_clk_in(clk), .nrst_in(nrst),
    .config_select_low_in(sel_lo), .config_select_high_in(sel_hi),
    .pnp_enable_n_in(pnp_n), .pnp_key_in(key), .bank_port_bit_in(port_bit),
    .dbus_addr_in(addr), .dbus_wdata_in(wdata), .dbus_wr_in(wr),
    .dbus_rd_in(rd), .uart_div_low_in(div_low), .fetch_req_in(freq),
    .dbus_rdata_out(rdata), .mode_out(mode), .uart_enable_out(uart_en),
    .parallel_if_enable_out(par_en), .serial_if_enable_out(ser_en),
    .pnp_mode_out(pnp), .bank_select_out(bank), .dsp_reset_n_out(dsp_n),
    .line_control_out0(lc0), .line_control_out1(lc1),
    .line_control_out2(lc2), .uart_clk_out(uclk), .uart_tick_out(tick),
    .addr_latch_pulse_out(ale), .prog_fetch_n_out(prog_fetch_n_n));
  //////////////////////////////////////////////////////////////////////////
  // compare, verdict and bus cycles
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic bus_wr(input logic [19:0] a, input logic [7:0] d);
    @(negedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(negedge clk);
    wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [19:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr <= a; rd <= 1'b1;
    @(negedge clk);
    rd <= 1'b0;
    chk(rdata, exp);
    cyc(1);
    chk(rdata, MCG_READ_ZERO);
  endtask : bus_rd
  // spacing of uart ticks, after the old ratio has drained
  task automatic period(input logic [7:0] exp);
    for (i = 0; i < 3; i++) begin
      n = 0;
      do begin cyc(1); n++; end while (tick !== 1'b1 && n < 200);
    end
    chk(n[7:0], exp);
    chk({7'h00, uclk}, 8'h01);
  endtask : period
  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    chk({rdata}, 8'h00);
    chk({dsp_n, lc0, lc1, lc2, bank, prog_fetch_n_n, ale}, 8'h02);
    period(8'd6);
    $display("test reset done");
  endtask : t_reset
  task automatic t_modes;
    logic [7:0] exp [4] = '{8'h18, 8'h44, 8'h80, 8'h80};
    for (int k = 0; k < 4; k++) begin
      sel_hi <= k[1]; sel_lo <= k[0];
      cyc(6);
      chk({mode, 1'b0, uart_en, par_en, ser_en, 2'b00}, exp[k]);
    end
    sel_hi <= 1'b0; sel_lo <= 1'b0;
    $display("test modes done");
  endtask : t_modes
  task automatic t_line;
    bus_wr(MCG_ADDR_LINE_PORT, 8'h16);
    chk({dsp_n, lc0, lc1, lc2}, 8'h07);
    bus_wr(MCG_ADDR_LINE_PORT, 8'hE9);
    chk({dsp_n, lc0, lc1, lc2}, 8'h08);
    bus_rd(MCG_ADDR_LINE_PORT, 8'h00);
    $display("test line done");
  endtask : t_line
  task automatic t_readback;
    div_low <= 8'hA5;
    bus_rd(MCG_ADDR_DIV_READ, 8'hA5);
    div_low <= 8'h5A;
    bus_rd(MCG_ADDR_DIV_READ, 8'h5A);
    bus_rd(20'h0_EC01, 8'h00);
    $display("test readback done");
  endtask : t_readback
  task automatic t_divider;
    logic [7:0] val [5] = '{8'h81, 8'h02, 8'h40, 8'hFF, 8'h08};
    logic [7:0] per [5] = '{8'd2, 8'd2, 8'd64, 8'd64, 8'd8};
    for (int k = 0; k < 5; k++) begin
      bus_wr(MCG_ADDR_UART_CLK, val[k]);
      period(per[k]);
    end
    bus_rd(MCG_ADDR_UART_CLK, 8'h00);
    $display("test divider done");
  endtask : t_divider
  task automatic do_jump(input logic u);
    @(negedge clk);
    jump <= 1'b1; upper <= u;
    cyc(1);
    jump <= 1'b0;
    cyc(1);
    chk({bank}, {7'h00, u});
  endtask : do_jump
  task automatic t_bank_fetch;
    do_jump(1'b1);
    cyc(1);
    chk({ale, prog_fetch_n_n}, 8'h03);
    jump <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      cyc(1);
      jump <= 1'b0;
      chk({ale, prog_fetch_n_n}, 8'h00);
    end
    cyc(1);
    chk({ale, prog_fetch_n_n}, 8'h01);
    cyc(2);
    chk({ale, prog_fetch_n_n}, 8'h01);
    cyc(8);
    do_jump(1'b0);
    cyc(8);
    $display("test bank_fetch done");
  endtask : t_bank_fetch
  task automatic t_pnp;
    pnp_n <= 1'b0;
    cyc(6);
    key <= 1'b1;
    cyc(1);
    key <= 1'b0;
    cyc(1);
    chk({pnp}, 8'h01);
    pnp_n <= 1'b1;
    cyc(6);
    chk({pnp}, 8'h00);
    key <= 1'b1;
    cyc(1);
    key <= 1'b0;
    cyc(2);
    chk({pnp}, 8'h00);
    $display("test pnp done");
  endtask : t_pnp
  // mid-run reset must drop written registers back to reset values
  task automatic t_rerun;
    bus_wr(MCG_ADDR_LINE_PORT, 8'h17);
    bus_wr(MCG_ADDR_UART_CLK, 8'h02);
    nrst <= 1'b0;
    cyc(4);
    nrst <= 1'b1;
    cyc(1);
    chk({dsp_n, lc0, lc1, lc2}, 8'h00);
    period(8'd6);
    $display("test rerun done");
  endtask : t_rerun
  //////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    cyc(12);
    nrst <= 1'b1;
    cyc(1);
    t_reset();
    t_modes();
    t_line();
    t_readback();
    t_divider();
    t_bank_fetch();
    t_pnp();
    t_rerun();
    results();
  end
  initial begin
    #(25 * 20000);
    miscompares++;
    results();
  end
endmodule : test_modem_controller_glue
`default_nettype wire
